// file: design/twc_config_bank.v
// Notes on behaviour
// - Programming uses only serial clock, active-low select and serial data.
// - Each word is 32 bits, most significant data bit first.
// - Bits shift in on clock rising edges only while select is low.
// - Four-bit address picks register; 0 to 7 are operational registers.
// - Registers 0,1,2 reset to A2919A3, 0550288, EAFF1DC.
// - Registers 3,4,5 reset to 9EC0008, 0C00080, 8000070.
// - Register 6 resets to 8000000, register 7 to 10061B2.
// - Test registers 8 and 9 reset to 1E0F401 and 14C0402.
// - Preset mode code is clock, data, select pins, clock as MSB.
// - Preset 5 uses 18.414 MHz, ratios 18 and 1539, 1.023 MHz IF.
// - High preset select pin enters preset mode; serial pins are straps.
// - Clearing power bit stops device except the serial bus.
`timescale 1ns/1ps
`include "twc_defs.vh"
module twc_config_bank
(
  input wire mclk,
  input wire nrst,
  input wire serialClk,
  input wire chipSelectN,
  input wire serial_write_line,
  input wire preset_strap_select,
  output reg [27:0] rx_if_config,
  output reg [27:0] agc_output_config,
  output reg [27:0] filter_agc_support_config,
  output reg [27:0] synth_vco_clock_config,
  output reg [27:0] synth_integer_ref_ratio,
  output reg [27:0] synth_fraction_ratio,
  output reg [27:0] stream_frame_control,
  output reg [27:0] sample_clock_fraction,
  output reg [27:0] factory_test_a,
  output reg [27:0] factory_test_b,
  output reg device_power_on_bit,
  output reg presetActive_r,
  output reg [2:0] presetState_r,
  output reg [15:0] presetIfKhz_r,
  output reg [7:0] presetRefRatio_r,
  output reg [12:0] presetMainRatio_r,
  output reg writeStrobe_r
);
  wire [3:0] pinLevel;
  reg sclkPrev_r;
  reg selPrev_r;
  reg [31:0] shift_r;
  reg [5:0] bitCount_r;
  wire sclkRise;
  wire csRise;
  wire csLow;
  wire inPreset;
  // ----------------------------------------
  // Pin sampling, only the three serial pins plus preset strap
  // ----------------------------------------
  twc_pin_sync #(.WIDTH(4)) pinSync
  (
    .mclk(mclk),
    .nrst(nrst),
    // Select enters inverted so the synchroniser's reset level is the idle level
    .pinIn({preset_strap_select, serialClk, serial_write_line, ~chipSelectN}),
    .pinLevel_r(pinLevel)
  );
  assign inPreset = pinLevel[3];
  assign csLow = pinLevel[0] & ~inPreset;
  assign sclkRise = pinLevel[2] & ~sclkPrev_r;
  assign csRise = ~pinLevel[0] & selPrev_r;
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Undo the select inversion: straps read as pin levels
  function [2:0] strapCode;
    input [2:0] levels;
    begin
      strapCode = {levels[2:1], ~levels[0]};
    end
  endfunction
  function knownAddr;
    input [3:0] addr;
    begin
      knownAddr = (addr <= `TWC_A_TEST_B);
    end
  endfunction
  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      sclkPrev_r <= 1'b0;
      selPrev_r <= 1'b0;
      shift_r <= 32'h0000_0000;
      bitCount_r <= 6'h00;
    end
    else
    begin
      sclkPrev_r <= pinLevel[2];
      selPrev_r <= pinLevel[0];
      if (csLow && sclkRise)
      begin
        shift_r <= {shift_r[30:0], pinLevel[1]};
        // Saturates, so an overlong word keeps its last 32 bits
        if (bitCount_r != 6'h20)
          bitCount_r <= bitCount_r + 6'h01;
      end
      else if (!csLow)
        bitCount_r <= 6'h00;
    end
  end
  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  // Short words are dropped rather than committed half-shifted; overlong words commit their last 32 bits
  wire commit = csRise && !inPreset && (bitCount_r == 6'h20);
  wire [27:0] wData = shift_r[31:4];
  wire [3:0] wAddr = shift_r[3:0];
  // Unknown addresses vanish without a strobe
  wire addrOk = knownAddr(wAddr);
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_if_config <= `TWC_R_RX_IF;
      agc_output_config <= `TWC_R_AGC_OUT;
      filter_agc_support_config <= `TWC_R_FILT_AGC;
      synth_vco_clock_config <= `TWC_R_SYNTH_VCO;
      synth_integer_ref_ratio <= `TWC_R_SYNTH_INT;
      synth_fraction_ratio <= `TWC_R_SYNTH_FRAC;
      stream_frame_control <= `TWC_R_STREAM;
      sample_clock_fraction <= `TWC_R_SAMPLE_CLK;
      factory_test_a <= `TWC_R_TEST_A;
      factory_test_b <= `TWC_R_TEST_B;
      writeStrobe_r <= 1'b0;
    end
    else
    begin
      writeStrobe_r <= commit & addrOk;
      if (commit)
      begin
        case (wAddr)
          `TWC_A_RX_IF: rx_if_config <= wData;
          `TWC_A_AGC_OUT: agc_output_config <= wData;
          `TWC_A_FILT_AGC: filter_agc_support_config <= wData;
          `TWC_A_SYNTH_VCO: synth_vco_clock_config <= wData;
          `TWC_A_SYNTH_INT: synth_integer_ref_ratio <= wData;
          `TWC_A_SYNTH_FRAC: synth_fraction_ratio <= wData;
          `TWC_A_STREAM: stream_frame_control <= wData;
          `TWC_A_SAMPLE_CLK: sample_clock_fraction <= wData;
          `TWC_A_TEST_A: factory_test_a <= wData;
          `TWC_A_TEST_B: factory_test_b <= wData;
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Power enable; serial logic never gated by it
  // Straps cannot program the power bit, so preset forces it on
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!nrst)
      device_power_on_bit <= 1'b1;
    else
      device_power_on_bit <= rx_if_config[`TWC_PWR_BIT] | presetActive_r;
  end
  // ----------------------------------------
  // Preset state decode
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      presetActive_r <= 1'b0;
      presetState_r <= 3'h0;
      presetIfKhz_r <= 16'h0000;
      presetRefRatio_r <= 8'h00;
      presetMainRatio_r <= 13'h0000;
    end
    else
    begin
      presetActive_r <= inPreset;
      if (inPreset)
      begin
        presetState_r <= strapCode(pinLevel[2:0]);
        if (strapCode(pinLevel[2:0]) == `TWC_PRESET_LOW_IF)
          presetIfKhz_r <= `TWC_IF_KHZ_LOW;
        else
          presetIfKhz_r <= `TWC_IF_KHZ_STD;
        case (strapCode(pinLevel[2:0]))
          3'h3:
          begin
            presetRefRatio_r <= 8'h20;
            presetMainRatio_r <= 13'h0600;
          end
          3'h4:
          begin
            presetRefRatio_r <= 8'h60;
            presetMainRatio_r <= 13'h1eb1;
          end
          3'h5:
          begin
            presetRefRatio_r <= 8'h12;
            presetMainRatio_r <= 13'h0603;
          end
          3'h6:
          begin
            presetRefRatio_r <= 8'h41;
            presetMainRatio_r <= 13'h1eb1;
          end
          default:
          begin
            presetRefRatio_r <= 8'h10;
            presetMainRatio_r <= 13'h0600;
          end
        endcase
      end
    end
  end
endmodule

// file: design/twc_defs.vh
`ifndef TWC_DEFS_VH
`define TWC_DEFS_VH
// ----------------------------------------
// Word layout
// ----------------------------------------
`define TWC_WORD_BITS 32
`define TWC_DATA_BITS 28
`define TWC_ADDR_BITS 4
`define TWC_NUM_REGS 10
`define TWC_PWR_BIT 27
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TWC_A_RX_IF 4'h0
`define TWC_A_AGC_OUT 4'h1
`define TWC_A_FILT_AGC 4'h2
`define TWC_A_SYNTH_VCO 4'h3
`define TWC_A_SYNTH_INT 4'h4
`define TWC_A_SYNTH_FRAC 4'h5
`define TWC_A_STREAM 4'h6
`define TWC_A_SAMPLE_CLK 4'h7
`define TWC_A_TEST_A 4'h8
`define TWC_A_TEST_B 4'h9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TWC_R_RX_IF 28'ha29_19a3
`define TWC_R_AGC_OUT 28'h055_0288
`define TWC_R_FILT_AGC 28'heaf_f1dc
`define TWC_R_SYNTH_VCO 28'h9ec_0008
`define TWC_R_SYNTH_INT 28'h0c0_0080
`define TWC_R_SYNTH_FRAC 28'h800_0070
`define TWC_R_STREAM 28'h800_0000
`define TWC_R_SAMPLE_CLK 28'h100_61b2
`define TWC_R_TEST_A 28'h1e0_f401
`define TWC_R_TEST_B 28'h14c_0402
// ----------------------------------------
// Preset IF centre, kHz
// ----------------------------------------
`define TWC_IF_KHZ_LOW 16'h03ff
`define TWC_IF_KHZ_STD 16'h0ffc
`define TWC_PRESET_LOW_IF 3'h5
`endif

// file: design/twc_pin_sync.v
`timescale 1ns/1ps
module twc_pin_sync
#(
  parameter WIDTH = 1
)
(
  input wire mclk,
  input wire nrst,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinLevel_r
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;
  // ----------------------------------------
  // Three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
      pinLevel_r <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      pinLevel_r <= (stage2_r & stage3_r) | (pinLevel_r & (stage2_r | stage3_r));
    end
  end
endmodule

// file: dv/twc_config_bank_props.sv
`timescale 1ns/1ps
module twc_config_bank_props
(
  input wire mclk,
  input wire nrst,
  input wire chipSelectN,
  input wire [27:0] rx_if_config,
  input wire device_power_on_bit,
  input wire presetActive_r,
  input wire [2:0] presetState_r,
  input wire [15:0] presetIfKhz_r,
  input wire writeStrobe_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_strobe_pulse: assert property (writeStrobe_r |=> !writeStrobe_r)
    else $error("strobe too long");
  a_reset_dflt: assert property (disable iff (1'b0) !nrst |=>
    rx_if_config == 28'ha29_19a3 && !writeStrobe_r && device_power_on_bit)
    else $error("bad reset state");
  a_reg_cause: assert property ($changed(rx_if_config) |->
    writeStrobe_r || $past(writeStrobe_r)) else $error("register changed alone");
  a_strobe_cs: assert property (writeStrobe_r |->
    chipSelectN && $past(chipSelectN, 3)) else $error("strobe without select rise");
  a_power_mirror: assert property (!presetActive_r && !$past(presetActive_r) &&
    $stable(rx_if_config[27]) |-> device_power_on_bit == rx_if_config[27])
    else $error("power bit mismatch");
  a_preset_power: assert property ($past(presetActive_r) && presetActive_r
    |-> device_power_on_bit) else $error("preset not powered");
  a_preset_quiet: assert property ($past(presetActive_r) && presetActive_r
    |-> !writeStrobe_r) else $error("write in preset");
  a_preset_if: assert property ($past(presetActive_r) && presetActive_r &&
    $stable(presetState_r) |->
    presetIfKhz_r == (presetState_r == 3'h5 ? 16'h03ff : 16'h0ffc)) else $error("bad IF");
  cover property (writeStrobe_r);
  cover property (presetActive_r && presetState_r == 3'h5);
  cover property (!device_power_on_bit);
endmodule
bind twc_config_bank twc_config_bank_props u_twc_config_bank_props (.mclk, .nrst,
  .chipSelectN, .rx_if_config, .device_power_on_bit, .presetActive_r, .presetState_r,
  .presetIfKhz_r, .writeStrobe_r);

// file: dv/twc_serial_master.sv
`timescale 1ns/1ps
module twc_serial_master
(
  input wire mclk,
  output reg serialClk,
  output reg chipSelectN,
  output reg serialData
);
  integer i;
  initial
  begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialData = 1'b0;
  end
  // Clock still outside frames; n below 32 gives a short word
  task send(input [31:0] w, input integer n);
  begin
    repeat (8) @(negedge mclk);
    chipSelectN = 1'b0;
    for (i = 31; i > 31 - n; i = i - 1)
    begin
      serialData = w[i];
      repeat (4) @(negedge mclk);
      serialClk = 1'b1;
      repeat (4) @(negedge mclk);
      serialClk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    chipSelectN = 1'b1;
    serialData = ~serialData; // Released line must not look held
  end
  endtask
  task strap(input [2:0] c);
    {serialClk, serialData, chipSelectN} = c;
  endtask
endmodule

// file: dv/twc_config_bank_tb_top.sv
`timescale 1ns/1ps
module twc_config_bank_tb_top;
  reg mclk = 1'b0;
  reg nrst = 1'b0;
  reg psel = 1'b0;
  wire sclk, csN, sdat, pwr, pAct, strobe;
  wire [2:0] pState;
  wire [15:0] pIf;
  wire [7:0] pRef;
  wire [12:0] pMain;
  wire [27:0] regs [0:9];
  reg [27:0] expReg [0:9] = '{28'ha29_19a3, 28'h055_0288, 28'heaf_f1dc, 28'h9ec_0008,
    28'h0c0_0080, 28'h800_0070, 28'h800_0000, 28'h100_61b2, 28'h1e0_f401, 28'h14c_0402};
  reg [7:0] expRef [0:7] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h60, 8'h12, 8'h41, 8'h10};
  reg [12:0] expMain [0:7] = '{13'h0600, 13'h0600, 13'h0600, 13'h0600, 13'h1eb1, 13'h0603,
    13'h1eb1, 13'h0600};
  integer error_cnt = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer k;
  integer t;
  always #12.5 mclk = ~mclk;
  twc_serial_master u_twc_serial_master (.mclk(mclk), .serialClk(sclk), .chipSelectN(csN),
    .serialData(sdat));
  twc_config_bank u_twc_config_bank (.mclk(mclk), .nrst(nrst), .serialClk(sclk),
    .chipSelectN(csN), .serial_write_line(sdat), .preset_strap_select(psel),
    .rx_if_config(regs[0]), .agc_output_config(regs[1]), .filter_agc_support_config(regs[2]),
    .synth_vco_clock_config(regs[3]), .synth_integer_ref_ratio(regs[4]),
    .synth_fraction_ratio(regs[5]), .stream_frame_control(regs[6]),
    .sample_clock_fraction(regs[7]), .factory_test_a(regs[8]), .factory_test_b(regs[9]),
    .device_power_on_bit(pwr), .presetActive_r(pAct), .presetState_r(pState),
    .presetIfKhz_r(pIf), .presetRefRatio_r(pRef), .presetMainRatio_r(pMain),
    .writeStrobe_r(strobe));
  task chk(input [27:0] seen, input [27:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task chk_all;
    for (k = 0; k < 10; k = k + 1)
      chk(regs[k], expReg[k]);
  endtask
  // Dropped words must give no strobe and leave every register alone
  task wr(input [3:0] a, input [27:0] d, input integer n, input ok);
    integer w;
  begin
    u_twc_serial_master.send({d, a}, n);
    // Own counter: callers loop on t
    for (w = 0; w < 20 && strobe !== 1'b1; w = w + 1)
      @(negedge mclk);
    chk(w < 20, ok);
    if (ok)
      expReg[a] = d;
    repeat (2) @(negedge mclk);
    chk_all;
  end
  endtask
  task t_write;
  begin
    for (t = 0; t < 10; t = t + 1)
      wr(t[3:0], 28'h35c_a000 | t[3:0], 32, 1'b1);
    chk(pwr, 0);
    wr(4'h0, 28'hfff_ffff, 32, 1'b1);
    chk(pwr, 1);
    wr(4'h2, 28'h123_4567, 31, 1'b0);
    wr(4'hc, 28'h123_4567, 32, 1'b0);
    $display("t_write done");
  end
  endtask
  task t_preset;
  begin
    psel = 1'b1;
    for (t = 0; t < 8; t = t + 1)
    begin
      u_twc_serial_master.strap(t[2:0]);
      repeat (12) @(negedge mclk);
      chk(pState, t[2:0]);
      chk(pIf, t == 5 ? 16'h03ff : 16'h0ffc);
      chk(pRef, expRef[t]);
      chk(pMain, expMain[t]);
      chk(pAct, 1);
      chk(pwr, 1);
      if (t == 5)
      begin
        chk(pRef, 8'h12);
        chk(pMain, 13'h0603);
      end
    end
    u_twc_serial_master.strap(3'h1);
    wr(4'h1, 28'h000_0000, 32, 1'b0);
    psel = 1'b0;
    repeat (12) @(negedge mclk);
    chk(pAct, 0);
    $display("t_preset done");
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  initial
  begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);
    chk_all;
    chk(pwr, 1);
    t_write;
    t_preset;
    results;
  end
endmodule
